/* gpib_ctrl_model.sv */
// Purpose: active controller model on the far side of the bus
// Assumes: bench resolves wired lines; high output pulls a line low
// Notes:   fixed settle before data valid; slow knob stretches handshakes
module gpib_ctrl_model
  import gpib_port_pkg::*;
(
  // clock and resolved bus levels
  input  wire logic              i_mclk,
  input  wire logic [DATA_W-1:0] i_dio_n,
  input  wire logic              i_dav_n,
  input  wire logic              i_nrfd_n,
  input  wire logic              i_ndac_n,
  input  wire logic              i_eoi_n,
  // pull requests
  output logic      [DATA_W-1:0] o_dio,
  output logic                   o_dav,
  output logic                   o_nrfd,
  output logic                   o_ndac,
  output logic                   o_atn,
  output logic                   o_eoi
);
  // everything released at start, lines float high
  initial begin
    {o_dio, o_dav, o_nrfd, o_ndac, o_atn, o_eoi} = '0;
  end

  task automatic tick();
    @(posedge i_mclk);
    #1;
  endtask

  // source one byte; sole controller owns attention
  task automatic send(input logic atn, input logic [7:0] b, input logic eoi, input int slow);
    int n;
    o_nrfd = 1'b0;
    o_ndac = 1'b0;
    o_atn = atn;
    repeat (4) tick();
    for (n = 0; n < 400 && !i_nrfd_n; n++) tick();
    o_dio = b;
    o_eoi = eoi;
    repeat (2) tick();
    o_dav = 1'b1;
    for (n = 0; n < 400 && !i_ndac_n; n++) tick();
    repeat (slow) tick();
    o_dav = 1'b0;
    o_dio = '0;
    o_eoi = 1'b0;
    // stay a not-ready acceptor, so a freshly addressed talker waits for us
    o_nrfd = 1'b1;
    o_ndac = 1'b1;
    o_atn = 1'b0;
    tick();
  endtask

  // accept one byte; ends holding both lines like a busy listener
  task automatic recv(output logic [7:0] b, output logic e, input int slow);
    int n;
    o_ndac = 1'b1;
    o_nrfd = 1'b1;
    repeat (slow + 1) tick();
    o_nrfd = 1'b0;
    for (n = 0; n < 400 && i_dav_n; n++) tick();
    b = ~i_dio_n;
    e = !i_eoi_n;
    o_nrfd = 1'b1;
    repeat (slow + 1) tick();
    o_ndac = 1'b0;
    for (n = 0; n < 400 && !i_dav_n; n++) tick();
    o_ndac = 1'b1;
  endtask
endmodule

/* gpib_fifo.sv */
// Purpose: small flip-flop FIFO with valid/ready on both sides
// Assumes: single clock, synchronous reset
// Notes:   no bypass; one cycle from write to read
module gpib_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_srst,
  // fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem[rd_ptr];

  // pointer arithmetic wraps at the depth
  always_comb begin
    next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end
endmodule

/* gpib_port.sv */
// Purpose: instrument talker/listener port on the parallel instrument bus
// Assumes: bus pins arrive as levels, negative true; inputs sync to i_mclk
// Notes:   received data passes through a 16 word FIFO to the parser
module gpib_port
  import gpib_port_pkg::*;
(
  // clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_srst,
  // bus data lines, low true
  input  wire logic [DATA_W-1:0] i_dio_n,
  output logic      [DATA_W-1:0] o_dio_n,
  output logic      [DATA_W-1:0] o_dio_oe,
  // bus handshake lines, low true, open drain
  input  wire logic              i_dav_n,
  output logic                   o_dav_oe,
  input  wire logic              i_nrfd_n,
  output logic                   o_nrfd_oe,
  input  wire logic              i_ndac_n,
  output logic                   o_ndac_oe,
  // bus control lines, low true
  input  wire logic              i_atn_n,
  input  wire logic              i_ren_n,
  input  wire logic              i_ifc_n,
  input  wire logic              i_eoi_n,
  output logic                   o_eoi_oe,
  output logic                   o_srq_oe,
  // instrument side
  input  wire logic [4:0]        i_my_addr,
  input  wire logic              i_front_panel_local_key,
  input  wire logic              i_srq_request,
  input  wire logic [DATA_W-1:0] i_status,
  // received data to parser
  output logic                   o_rx_valid,
  input  wire logic              i_rx_ready,
  output logic      [DATA_W-1:0] o_rx_data,
  // talk data from instrument; i_tx_last sends TERM_CHAR with end flag in place of i_tx_data
  input  wire logic              i_tx_valid,
  output logic                   o_tx_ready,
  input  wire logic [DATA_W-1:0] i_tx_data,
  input  wire logic              i_tx_last,
  // status outputs
  output logic                   o_remote,
  output logic                   o_lockout,
  output logic                   o_listen,
  output logic                   o_talk,
  output logic                   o_dev_clear,
  output logic                   o_trigger,
  output logic                   o_panel_enable
);
  import gpib_port_pkg::*;

  // three-stage: two-flop sync plus one stable sample
  localparam int NSYNC = DATA_W + 6;
  logic [NSYNC-1:0] s1, s2, s3;
  logic [NSYNC-1:0] raw;
  logic [DATA_W-1:0] dio;
  logic atn, dav, nrfd, ndac, ren, ifc, eoi;

  // bus lines inverted to true-high, then synchronised
  assign raw = ~{i_dio_n, i_atn_n, i_dav_n, i_nrfd_n, i_ndac_n, i_ren_n, i_ifc_n};
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // data, attention and data-valid must agree in two samples; our own
  // nrfd/ndac pulls are left out so they cannot break a byte being held
  always_comb begin
    {dio, atn, dav, nrfd, ndac, ren, ifc} = s3;
    if (s2[NSYNC-1 -: DATA_W+2] != s3[NSYNC-1 -: DATA_W+2]) begin
      dav = 1'b0;
    end
  end
  logic eoi_s1, eoi_s2;
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      eoi_s1 <= 1'b0;
      eoi_s2 <= 1'b0;
    end else begin
      eoi_s1 <= ~i_eoi_n;
      eoi_s2 <= eoi_s1;
    end
  end
  assign eoi = eoi_s2;

  function automatic logic [2:0] grp(input logic [7:0] b);
    grp = 3'((b & CMD_MASK) >> GRP_SHIFT);
  endfunction

  // ---------------- state ----------------
  logic lacs, tacs, spas, rem, llo, acc_busy, term_pend, srq_st, stb_read;
  logic next_lacs, next_tacs, next_spas, next_rem, next_llo;
  logic next_acc_busy, next_term_pend, next_srq_st;
  logic dclr, trig, next_dclr, next_trig;
  logic [7:0] cmd;
  logic       new_byte;
  logic       fifo_in_valid, fifo_in_ready;
  logic [7:0] fifo_in_data;

  assign cmd      = dio & CMD_MASK;
  // acceptor takes a byte when data-valid rises and it is not mid-byte
  assign new_byte = dav && !acc_busy && (atn || (lacs && fifo_in_ready));

  // acceptor, addressing, remote and clear logic
  always_comb begin
    next_lacs      = lacs;
    next_tacs      = tacs;
    next_spas      = spas;
    next_rem       = rem;
    next_llo       = llo;
    next_dclr      = 1'b0;
    next_trig      = 1'b0;
    next_term_pend = term_pend;
    next_acc_busy  = acc_busy ? dav : new_byte;
    fifo_in_valid  = 1'b0;
    fifo_in_data   = dio;
    if (term_pend) begin
      fifo_in_valid = 1'b1;
      fifo_in_data  = TERM_CHAR;
      if (fifo_in_ready) next_term_pend = 1'b0;
    end else if (new_byte && !atn) begin
      fifo_in_valid  = 1'b1;
      next_term_pend = eoi;
    end
    if (new_byte && atn) begin
      case (grp(cmd))
        3'h0: begin
          if (cmd == CMD_DCL) next_dclr = 1'b1;
          if (cmd == CMD_LLO) next_llo  = 1'b1;
          if (cmd == CMD_SPE) next_spas = 1'b1;
          if (cmd == CMD_SPD) next_spas = 1'b0;
          if (lacs && cmd == CMD_GTL) next_rem  = 1'b0;
          if (lacs && cmd == CMD_SDC) next_dclr = 1'b1;
          if (lacs && cmd == CMD_GET) next_trig = 1'b1;
        end
        3'h1: begin
          if (cmd == LAG_UNL) next_lacs = 1'b0;
          else if (cmd[4:0] == i_my_addr) begin
            next_lacs = 1'b1;
            if (ren) next_rem = 1'b1;
          end
        end
        3'h2: begin
          if (cmd == TAG_UNT) next_tacs = 1'b0;
          else next_tacs = (cmd[4:0] == i_my_addr);
        end
        default: ;
      endcase
    end
    if (!ren) begin
      next_rem = 1'b0;
      next_llo = 1'b0;
    end else if (i_front_panel_local_key && !llo) begin
      next_rem = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst || ifc) begin
      lacs      <= 1'b0;
      tacs      <= 1'b0;
      spas      <= 1'b0;
      rem       <= 1'b0;
      llo       <= 1'b0;
      acc_busy  <= 1'b0;
      term_pend <= 1'b0;
      dclr      <= 1'b0;
      trig      <= 1'b0;
    end else begin
      lacs      <= next_lacs;
      tacs      <= next_tacs;
      spas      <= next_spas;
      rem       <= next_rem;
      llo       <= next_llo;
      acc_busy  <= next_acc_busy;
      term_pend <= next_term_pend;
      dclr      <= next_dclr;
      trig      <= next_trig;
    end
  end

  // ---------------- source handshake ----------------
  src_state_e sh, next_sh;
  logic [2:0] settle, next_settle;
  logic [7:0] tx_byte, next_tx_byte;
  logic       tx_eoi, next_tx_eoi;
  logic       talking;
  assign talking    = tacs && !atn;
  assign o_tx_ready = talking && !spas && sh == SH_IDLE;
  assign stb_read   = spas && sh == SH_DONE && !ndac;

  always_comb begin
    next_sh      = sh;
    next_settle  = settle;
    next_tx_byte = tx_byte;
    next_tx_eoi  = tx_eoi;
    case (sh)
      SH_IDLE: begin
        if (talking && spas) begin
          next_tx_byte = i_status;
          next_tx_byte[SRQ_BIT] = srq_st;
          next_tx_eoi  = 1'b0;
          next_sh      = SH_WAIT;
        end else if (talking && i_tx_valid) begin
          next_tx_byte = i_tx_last ? TERM_CHAR : i_tx_data;
          next_tx_eoi  = i_tx_last;
          next_sh      = SH_WAIT;
        end
        next_settle = '0;
      end
      SH_WAIT: begin
        // data is out; wait for listeners ready and settle time
        if (!talking) next_sh = SH_IDLE;
        else if (nrfd || settle != SETTLE_MAX) begin
          if (settle != SETTLE_MAX) next_settle = settle + 3'h1;
        end else next_sh = SH_DAV;
      end
      SH_DAV: begin
        if (!talking) next_sh = SH_IDLE;
        else if (!ndac) next_sh = SH_DONE;
      end
      SH_DONE: next_sh = SH_IDLE;
      default: next_sh = SH_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst || ifc) begin
      sh      <= SH_IDLE;
      settle  <= '0;
      tx_byte <= '0;
      tx_eoi  <= 1'b0;
    end else begin
      sh      <= next_sh;
      settle  <= next_settle;
      tx_byte <= next_tx_byte;
      tx_eoi  <= next_tx_eoi;
    end
  end

  // service request: set wins over the clear by reading
  always_comb begin
    next_srq_st = srq_st;
    if (stb_read) next_srq_st = 1'b0;
    if (i_srq_request) next_srq_st = 1'b1;
  end
  always_ff @(posedge i_mclk) begin
    if (i_srst) srq_st <= 1'b0;
    else srq_st <= next_srq_st;
  end

  // ---------------- pin drive, open-drain style ----------------
  logic drive_data;
  assign drive_data = (sh == SH_WAIT || sh == SH_DAV) && talking;
  assign o_dio_n   = ~tx_byte;
  assign o_dio_oe  = drive_data ? tx_byte : '0;
  assign o_dav_oe  = (sh == SH_DAV) && talking;
  // listener holds not-ready while busy or buffer full
  assign o_nrfd_oe = (lacs || atn) && (acc_busy || (!atn && (!fifo_in_ready || term_pend)));
  // not-accepted low until byte taken
  assign o_ndac_oe = (lacs || atn) && !acc_busy && !new_byte;
  assign o_eoi_oe  = tx_eoi && drive_data;
  assign o_srq_oe  = srq_st;

  gpib_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .i_mclk      (i_mclk),
    .i_srst      (i_srst),
    .i_in_valid  (fifo_in_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (fifo_in_data),
    .o_out_valid (o_rx_valid),
    .i_out_ready (i_rx_ready),
    .o_out_data  (o_rx_data)
  );

  assign o_remote       = rem;
  assign o_lockout      = llo;
  assign o_listen       = lacs;
  assign o_talk         = tacs;
  assign o_dev_clear    = dclr;
  assign o_trigger      = trig;
  assign o_panel_enable = !rem;
endmodule

/* gpib_port_checker.sv */
// Purpose: pin checks for the bus port
// Assumes: one clock, sync reset high
// Notes:   sees only top ports, bound below
module gpib_port_checker
  import gpib_port_pkg::*;
(
  // watched pins
  input wire logic              i_mclk,
  input wire logic              i_srst,
  input wire logic              i_dav_n,
  input wire logic              i_nrfd_n,
  input wire logic              i_ndac_n,
  input wire logic              i_atn_n,
  input wire logic              i_ren_n,
  input wire logic              i_ifc_n,
  input wire logic              i_srq_request,
  input wire logic [DATA_W-1:0] o_dio_oe,
  input wire logic              o_dav_oe,
  input wire logic              o_nrfd_oe,
  input wire logic              o_ndac_oe,
  input wire logic              o_eoi_oe,
  input wire logic              o_srq_oe,
  input wire logic              o_remote,
  input wire logic              o_panel_enable,
  input wire logic              o_listen,
  input wire logic              o_talk
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // attention held past the input sync
  sequence s_atn_held;
    !i_atn_n [*7];
  endsequence
  // acceptor take: ndac freed, then nrfd pulled one cycle later
  sequence s_take;
    $fell(o_ndac_oe) ##1 $rose(o_nrfd_oe);
  endsequence
  chk_rst_release: assert property ($fell(i_srst) |->
    !(|o_dio_oe) && !o_dav_oe && !o_nrfd_oe && !o_ndac_oe && !o_eoi_oe && !o_srq_oe)
    else $error("line pulled after reset");
  // the take lags the pin by the sync depth, so look back at the two sampled levels
  chk_take_on_dav: assert property (s_take |-> $past(i_dav_n, 3) == 1'b0 && $past(i_dav_n, 4) == 1'b0)
    else $error("byte taken without data valid");
  // ready is judged on the synced level, the listener may pull again at once
  chk_dav_ready: assert property ($rose(o_dav_oe) |->
    $past(i_nrfd_n, 4) && o_dio_oe == $past(o_dio_oe, 3))
    else $error("data valid before ready or data");
  chk_dav_release: assert property ($fell(o_dav_oe) |-> $past(i_ndac_n, 4))
    else $error("data valid dropped early");
  chk_eoi_term: assert property (o_eoi_oe && o_dav_oe |-> o_dio_oe == TERM_CHAR)
    else $error("end flag on non terminator");
  chk_srq_set: assert property ($rose(i_srq_request) |-> ##[1:4] o_srq_oe)
    else $error("service request not raised");
  chk_remote_ren: assert property ($rose(o_remote) |-> !i_ren_n && !o_panel_enable)
    else $error("remote without remote enable");
  chk_ren_local: assert property (i_ren_n [*7] |-> !o_remote)
    else $error("remote held with enable off");
  chk_atn_quiet: assert property (s_atn_held |-> !o_dav_oe && !o_eoi_oe)
    else $error("device sourced under attention");
  chk_ifc_clear: assert property (!i_ifc_n [*7] |-> !o_listen && !o_talk)
    else $error("addressing kept through clear");
endmodule

bind gpib_port gpib_port_checker chk_u (.*);

/* gpib_port_pkg.sv */
// Purpose: shared constants for the bus talker/listener port
// Assumes: bus lines sampled on i_mclk, 40 MHz
// Notes:   command codes are the standard interface message codes
package gpib_port_pkg;
  localparam int          DATA_W     = 8;
  localparam int          FIFO_DEPTH = 16;
  // command groups and codes, attention true
  localparam logic [7:0]  LAG_LO     = 8'h20;
  localparam logic [7:0]  LAG_UNL    = 8'h3f;
  localparam logic [7:0]  TAG_LO     = 8'h40;
  localparam logic [7:0]  TAG_UNT    = 8'h5f;
  localparam logic [7:0]  SCG_LO     = 8'h60;
  localparam logic [7:0]  CMD_GTL    = 8'h01;
  localparam logic [7:0]  CMD_SDC    = 8'h04;
  localparam logic [7:0]  CMD_GET    = 8'h08;
  localparam logic [7:0]  CMD_LLO    = 8'h11;
  localparam logic [7:0]  CMD_DCL    = 8'h14;
  localparam logic [7:0]  CMD_SPE    = 8'h18;
  localparam logic [7:0]  CMD_SPD    = 8'h19;
  localparam logic [7:0]  CMD_MASK   = 8'h7f;
  localparam logic [2:0]  GRP_SHIFT  = 3'h5;
  localparam logic [7:0]  STB_RESET  = 8'h20;  // status reads back as a blank
  localparam int          SRQ_BIT    = 6;      // seventh data line
  localparam logic [7:0]  TERM_CHAR  = 8'h0a;  // message terminator
  // source handshake settle time before data-valid
  localparam int          SETTLE_NS  = 100;
  localparam int          CLK_NS     = 25;
  localparam int          SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0]  SETTLE_MAX = 3'(SETTLE_CYC);

  typedef enum logic [3:0] {
    SH_IDLE = 4'b0001,
    SH_WAIT = 4'b0010,
    SH_DAV  = 4'b0100,
    SH_DONE = 4'b1000
  } src_state_e;
endpackage

/* tb_gpib_port.sv */
// Purpose: self-checking bench for the bus talker/listener port
// Assumes: controller model sources commands; bench plays instrument side
// Notes:   random bytes from a fixed seed; waits are bounded
module tb_gpib_port;
  timeunit 1ns;
  timeprecision 100ps;
  import gpib_port_pkg::*;
  logic       i_mclk, i_srst, i_ren_n, i_ifc_n, i_front_panel_local_key;
  logic       i_srq_request, i_rx_ready, i_tx_valid, i_tx_last, e;
  logic [4:0] i_my_addr;
  logic [7:0] i_status, i_tx_data, c_dio, o_dio_n, o_dio_oe, o_rx_data, b, q[16];
  logic       o_dav_oe, o_nrfd_oe, o_ndac_oe, o_eoi_oe, o_srq_oe, o_rx_valid;
  logic       o_tx_ready, o_remote, o_lockout, o_listen, o_talk;
  logic       o_dev_clear, o_trigger, o_panel_enable;
  logic       c_dav, c_nrfd, c_ndac, c_atn, c_eoi;
  int         fails = 0, checked = 0, n_clr = 0, n_trg = 0, i;
  // wired-and of all pull requests
  wire [7:0]  i_dio_n  = ~((o_dio_oe & ~o_dio_n) | c_dio);
  wire        i_dav_n  = !(o_dav_oe | c_dav);
  wire        i_nrfd_n = !(o_nrfd_oe | c_nrfd);
  wire        i_ndac_n = !(o_ndac_oe | c_ndac);
  wire        i_eoi_n  = !(o_eoi_oe | c_eoi);
  wire        i_atn_n  = !c_atn;

  gpib_port dut_u (.*);
  gpib_ctrl_model ctrl_u (.i_mclk(i_mclk), .i_dio_n(i_dio_n), .i_dav_n(i_dav_n), .i_nrfd_n(i_nrfd_n),
    .i_ndac_n(i_ndac_n), .i_eoi_n(i_eoi_n), .o_dio(c_dio), .o_dav(c_dav), .o_nrfd(c_nrfd),
    .o_ndac(c_ndac), .o_atn(c_atn), .o_eoi(c_eoi));

  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  // count one-cycle pulses
  always @(posedge i_mclk) begin
    if (o_dev_clear === 1'b1) n_clr++;
    if (o_trigger === 1'b1) n_trg++;
  end

  function automatic logic [7:0] lad(input logic [4:0] a); return LAG_LO | 8'(a); endfunction
  function automatic logic [7:0] tad(input logic [4:0] a); return TAG_LO | 8'(a); endfunction
  function automatic logic [7:0] poll(input logic [7:0] s); return {s[7], 1'b1, s[5:0]}; endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic flag(input string what, input logic seen, input logic exp);
    check(what, {7'h00, seen}, {7'h00, exp});
  endtask
  task automatic final_report();
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tick();
    @(posedge i_mclk);
    #1;
  endtask
  // settle spans the three-stage input sync
  task automatic settle();
    repeat (6) tick();
  endtask
  task automatic cmd(input logic [7:0] c);
    ctrl_u.send(1'b1, c, 1'b0, $urandom_range(3));
    settle();
  endtask
  task automatic dat(input logic [7:0] d, input logic eoi);
    ctrl_u.send(1'b0, d, eoi, $urandom_range(3));
    settle();
  endtask
  task automatic pop(input logic [7:0] exp);
    int n;
    i_rx_ready = 1'b1;
    for (n = 0; n < 100 && o_rx_valid !== 1'b1; n++) tick();
    check("rx byte", o_rx_data, exp);
    tick();
    i_rx_ready = 1'b0;
    tick();
  endtask
  task automatic talk_byte(input logic [7:0] d, input logic last);
    int n;
    fork
      ctrl_u.recv(b, e, $urandom_range(4));
      begin
        i_tx_data = d;
        i_tx_last = last;
        i_tx_valid = 1'b1;
        for (n = 0; n < 100 && o_tx_ready !== 1'b1; n++) tick();
        tick();
        i_tx_valid = 1'b0;
      end
    join
  endtask

  // hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge i_mclk);
    fails++;
    final_report();
  end

  initial begin
    {i_srst, i_ren_n, i_ifc_n} = 3'b111;
    {i_front_panel_local_key, i_srq_request, i_rx_ready, i_tx_valid, i_tx_last} = '0;
    {i_status, i_tx_data} = '0;
    void'($urandom(44929));
    i_my_addr = 5'($urandom_range(29));
    repeat (8) @(posedge i_mclk);
    #1 i_srst = 1'b0;
    settle();
    check("idle pulls", {o_dio_oe | {o_dav_oe, o_nrfd_oe, o_ndac_oe, o_eoi_oe, o_srq_oe, 3'h0}}, 8'h00);
    i_ren_n = 1'b0;
    cmd(lad(i_my_addr ^ 5'h01));
    flag("foreign listen", o_listen, 1'b0);
    cmd(lad(i_my_addr));
    cmd(SCG_LO | 8'($urandom_range(31)));
    flag("listen", o_listen, 1'b1);
    flag("remote", o_remote, 1'b1);
    flag("panel", o_panel_enable, 1'b0);
    // end flag appends a terminator
    q[0] = 8'($urandom);
    q[1] = 8'($urandom);
    dat(q[0], 1'b0);
    dat(q[1], 1'b1);
    pop(q[0]);
    pop(q[1]);
    pop(TERM_CHAR);
    // fill until refused, drain with stalls
    for (i = 0; i < 16; i++) begin
      q[i] = 8'($urandom);
      dat(q[i], 1'b0);
    end
    flag("full hold", o_nrfd_oe, 1'b1);
    for (i = 0; i < 16; i++) begin
      repeat ($urandom_range(3)) tick();
      pop(q[i]);
    end
    flag("drained", o_rx_valid, 1'b0);
    cmd(CMD_GET);
    cmd(CMD_SDC);
    cmd(CMD_DCL);
    check("triggers", 8'(n_trg), 8'h01);
    check("clears", 8'(n_clr), 8'h02);
    cmd(CMD_LLO);
    flag("lockout", o_lockout, 1'b1);
    i_front_panel_local_key = 1'b1;
    settle();
    flag("key locked", o_remote, 1'b1);
    i_front_panel_local_key = 1'b0;
    cmd(CMD_GTL);
    flag("gtl", o_remote, 1'b0);
    cmd(lad(i_my_addr));
    i_ren_n = 1'b1;
    settle();
    flag("ren local", o_remote, 1'b0);
    flag("lockout off", o_lockout, 1'b0);
    i_ren_n = 1'b0;
    cmd(lad(i_my_addr));
    i_front_panel_local_key = 1'b1;
    settle();
    flag("local key", o_remote, 1'b0);
    i_front_panel_local_key = 1'b0;
    cmd(LAG_UNL);
    flag("unlisten", o_listen, 1'b0);
    dat(8'($urandom), 1'b0);
    flag("not listening", o_rx_valid, 1'b0);
    cmd(tad(i_my_addr));
    flag("talk", o_talk, 1'b1);
    for (i = 0; i < 4; i++) begin
      q[i] = 8'($urandom);
      talk_byte(q[i], i == 3);
      check("tx byte", b, (i == 3) ? TERM_CHAR : q[i]);
      flag("tx eoi", e, i == 3);
    end
    cmd(TAG_UNT);
    flag("untalk", o_talk, 1'b0);
    // poll returns status with service bit, then clears it
    i_status = 8'($urandom);
    i_srq_request = 1'b1;
    tick();
    i_srq_request = 1'b0;
    settle();
    flag("srq", o_srq_oe, 1'b1);
    cmd(CMD_SPE);
    cmd(tad(i_my_addr));
    ctrl_u.recv(b, e, 2);
    settle();
    check("poll byte", b, poll(i_status));
    flag("srq cleared", o_srq_oe, 1'b0);
    cmd(CMD_SPD);
    cmd(lad(i_my_addr));
    i_ifc_n = 1'b0;
    repeat (10) tick();
    i_ifc_n = 1'b1;
    settle();
    flag("ifc listen", o_listen, 1'b0);
    flag("ifc talk", o_talk, 1'b0);
    final_report();
  end
endmodule
